// File: rtl/slic_cache.sv
`timescale 1ns/1ns
`default_nettype none
`include "slic_regs.svh"
// Contract
// - Store 512 bytes as four segments of 128 bytes.
// - Each segment has a 22-bit base tag compared against fetch address.
// - Eight subsegments per segment, four 32-bit long words each.
// - Hit needs tag match and the addressed subsegment valid flag.
// - Memory fill only on a miss; hits make no memory traffic.
// - On full tag miss replace the least recently used segment.
// - Usage kept in a four-entry two-bit stack; used goes on top.
// - Each fill loads one whole subsegment; others stay unfilled.
// - Lookup, fill and replacement are automatic and transparent.
// - PC is a bit address; its lowest four bits are ignored as zero.
// - Drive 28-bit word address valid by address strobe falling edge.
// - With narrow bus low, two word accesses per long word via bit 0.
// - Host flush request clears all valid flags, but only while seen in the idle state.
module slic_cache (
	input  wire logic        MCLK_I,
	input  wire logic        RSTN_I,
	input  wire logic        FETCH_REQ_I,
	input  wire logic [31:0] FETCH_PC_I,
	output logic             FETCH_ACK_O,
	output logic [15:0]      FETCH_INSTR_O,
	input  wire logic        FLUSH_REQ_I,
	output logic             MEM_REQ_O,
	input  wire logic        MEM_RDY_I,
	input  wire logic        NARROW_BUS_N_I,
	output logic             ADDRESS_LATCH_STROBE_O,
	input  wire logic [31:0] LOCAL_ADDR_DATA_BUS_I,
	output logic [31:0]      LOCAL_ADDR_DATA_BUS_O,
	output logic             LOCAL_ADDR_DATA_BUS_OE_O
);
	import slic_pkg::*;
	localparam int NSEG = `SLIC_SEGMENTS;
	localparam int NSUB = `SLIC_SUBSEGS;
	localparam int NWRD = `SLIC_WORDS_PER_SUB;

	logic [31:0]  mem_array [NSEG*NSUB*NWRD];
	slic_tag_t    tag_reg [NSEG];
	logic [NSUB-1:0] valid_reg [NSEG];
	slic_state_t  state_reg;
	slic_seg_t    fill_seg_reg;
	slic_tag_t    fill_tag_reg;
	slic_sub_t    fill_sub_reg;
	slic_word_t   fill_word_reg;
	logic         fill_half_reg;
	logic [15:0]  low_half_reg;
	logic         narrow_s1_reg;
	logic         narrow_reg;
	logic         rdy_s1_reg;
	logic         rdy_reg;
	logic         flush_s1_reg;
	logic         flush_reg;
	logic [31:0]  bus_s1_reg;
	logic [31:0]  bus_reg;

	function automatic logic [6:0] word_index(slic_seg_t s, slic_sub_t b,
		slic_word_t w);
		word_index = {s, b, w};
	endfunction

	// Bits 3:0 of the bit address are ignored so they act as zero.
	slic_tag_t  pc_tag;
	slic_sub_t  pc_sub;
	slic_word_t pc_word;
	logic       pc_half;
	assign pc_tag  = FETCH_PC_I[31:`SLIC_TAG_LSB];
	assign pc_sub  = FETCH_PC_I[`SLIC_TAG_LSB-1:`SLIC_SUB_LSB];
	assign pc_word = FETCH_PC_I[`SLIC_SUB_LSB-1:`SLIC_WORD_LSB];
	assign pc_half = FETCH_PC_I[`SLIC_PC_LSB_ZERO];

	logic [NSEG-1:0] tag_match;
	logic       any_match;
	slic_seg_t  match_seg;
	logic       hit;
	always_comb begin
		any_match = 1'b0;
		match_seg = 2'h0;
		for (int s = 0; s < NSEG; s++) begin
			tag_match[s] = (tag_reg[s] == pc_tag);
			if (tag_match[s] && !any_match) begin
				any_match = 1'b1;
				match_seg = slic_seg_t'(s);
			end
		end
	end
	assign hit = any_match && valid_reg[match_seg][pc_sub];

	slic_seg_t lru_seg;
	logic      lru_touch;
	slic_seg_t lru_touch_seg;
	logic      start_fill;
	assign start_fill = (state_reg == ST_IDLE) && FETCH_REQ_I && !hit &&
		!flush_reg;
	assign lru_touch = (state_reg == ST_IDLE) && FETCH_REQ_I && !flush_reg &&
		(hit || start_fill);
	assign lru_touch_seg = any_match ? match_seg : lru_seg;

	slic_lru u_lru (
		.MCLK_I  (MCLK_I),
		.RSTN_I  (RSTN_I),
		.touch_i (lru_touch),
		.seg_i   (lru_touch_seg),
		.lru_o   (lru_seg)
	);

	always_ff @(posedge MCLK_I or negedge RSTN_I) begin
		if (!RSTN_I) begin
			narrow_s1_reg <= 1'b1;
			narrow_reg    <= 1'b1;
			rdy_s1_reg    <= 1'b0;
			rdy_reg       <= 1'b0;
			flush_s1_reg  <= 1'b0;
			flush_reg     <= 1'b0;
			bus_s1_reg    <= 32'h0;
			bus_reg       <= 32'h0;
		end else begin
			narrow_s1_reg <= NARROW_BUS_N_I;
			narrow_reg    <= narrow_s1_reg;
			rdy_s1_reg    <= MEM_RDY_I;
			rdy_reg       <= rdy_s1_reg;
			flush_s1_reg  <= FLUSH_REQ_I;
			flush_reg     <= flush_s1_reg;
			bus_s1_reg    <= LOCAL_ADDR_DATA_BUS_I;
			bus_reg       <= bus_s1_reg;
		end
	end

	// Data is taken when the synchronized ready falls so the bus copy has caught up.
	logic rdy_d_reg;
	always_ff @(posedge MCLK_I or negedge RSTN_I) begin
		if (!RSTN_I)
			rdy_d_reg <= 1'b0;
		else
			rdy_d_reg <= rdy_reg;
	end
	logic data_take;
	assign data_take = (state_reg == ST_DATA) && rdy_d_reg && !rdy_reg;
	logic last_beat;
	assign last_beat = (fill_word_reg == 2'h3) && (narrow_reg || fill_half_reg);

	always_ff @(posedge MCLK_I or negedge RSTN_I) begin
		if (!RSTN_I) begin
			state_reg <= ST_IDLE;
		end else begin
			case (state_reg)
				ST_IDLE:  if (start_fill) state_reg <= ST_ADDR;
				ST_ADDR:  state_reg <= ST_LATCH;
				ST_LATCH: state_reg <= ST_DATA;
				ST_DATA:  if (data_take)
					state_reg <= last_beat ? ST_DONE : ST_ADDR;
				ST_DONE:  state_reg <= ST_IDLE;
				default:  state_reg <= ST_IDLE;
			endcase
		end
	end

	always_ff @(posedge MCLK_I or negedge RSTN_I) begin
		if (!RSTN_I) begin
			fill_seg_reg  <= 2'h0;
			fill_tag_reg  <= 22'h0;
			fill_sub_reg  <= 3'h0;
			fill_word_reg <= 2'h0;
			fill_half_reg <= 1'b0;
			low_half_reg  <= 16'h0;
		end else if (start_fill) begin
			fill_seg_reg  <= lru_touch_seg;
			fill_tag_reg  <= pc_tag;
			fill_sub_reg  <= pc_sub;
			fill_word_reg <= 2'h0;
			fill_half_reg <= 1'b0;
		end else if (data_take) begin
			if (!narrow_reg && !fill_half_reg) begin
				fill_half_reg <= 1'b1;
				low_half_reg  <= bus_reg[15:0];
			end else begin
				fill_half_reg <= 1'b0;
				fill_word_reg <= fill_word_reg + 2'h1;
			end
		end
	end

	logic [31:0] fill_data;
	assign fill_data = narrow_reg ? bus_reg : {bus_reg[15:0], low_half_reg};
	always_ff @(posedge MCLK_I) begin
		if (data_take && (narrow_reg || fill_half_reg))
			mem_array[word_index(fill_seg_reg, fill_sub_reg, fill_word_reg)]
				<= fill_data;
	end

	always_ff @(posedge MCLK_I or negedge RSTN_I) begin
		if (!RSTN_I) begin
			for (int s = 0; s < NSEG; s++) begin
				tag_reg[s]   <= 22'h0;
				valid_reg[s] <= 8'h00;
			end
		end else if (flush_reg && state_reg == ST_IDLE) begin
			for (int s = 0; s < NSEG; s++)
				valid_reg[s] <= 8'h00;
		end else if (start_fill) begin
			tag_reg[lru_touch_seg] <= pc_tag;
			if (!any_match)
				valid_reg[lru_touch_seg] <= 8'h00;
			else
				valid_reg[lru_touch_seg][pc_sub] <= 1'b0;
		end else if (state_reg == ST_DONE) begin
			valid_reg[fill_seg_reg][fill_sub_reg] <= 1'b1;
		end
	end

	always_ff @(posedge MCLK_I or negedge RSTN_I) begin
		if (!RSTN_I) begin
			FETCH_ACK_O   <= 1'b0;
			FETCH_INSTR_O <= 16'h0;
		end else begin
			FETCH_ACK_O <= (state_reg == ST_IDLE) && FETCH_REQ_I && hit &&
				!flush_reg && !FETCH_ACK_O;
			if (hit) begin
				FETCH_INSTR_O <= pc_half ?
					mem_array[word_index(match_seg, pc_sub, pc_word)][31:16] :
					mem_array[word_index(match_seg, pc_sub, pc_word)][15:0];
			end
		end
	end

	logic [27:0] word_addr;
	assign word_addr = {fill_tag_reg, fill_sub_reg, fill_word_reg,
		fill_half_reg};
	always_ff @(posedge MCLK_I or negedge RSTN_I) begin
		if (!RSTN_I) begin
			MEM_REQ_O                <= 1'b0;
			ADDRESS_LATCH_STROBE_O   <= 1'b1;
			LOCAL_ADDR_DATA_BUS_O    <= 32'h0;
			LOCAL_ADDR_DATA_BUS_OE_O <= 1'b0;
		end else begin
			MEM_REQ_O <= (state_reg == ST_ADDR) || (state_reg == ST_LATCH) ||
				(state_reg == ST_DATA);
			ADDRESS_LATCH_STROBE_O <= !(state_reg == ST_LATCH);
			LOCAL_ADDR_DATA_BUS_OE_O <= (state_reg == ST_ADDR) ||
				(state_reg == ST_LATCH);
			LOCAL_ADDR_DATA_BUS_O <= {word_addr, 4'h0};
		end
	end

	a_hit_no_mem: assert property (@(posedge MCLK_I) disable iff (!RSTN_I)
		(state_reg == ST_IDLE && FETCH_REQ_I && hit) |=> !MEM_REQ_O)
		else $error("Memory request raised on a cache hit.");
	a_addr_at_strobe: assert property (@(posedge MCLK_I) disable iff (!RSTN_I)
		$fell(ADDRESS_LATCH_STROBE_O) |-> LOCAL_ADDR_DATA_BUS_OE_O &&
		$past(LOCAL_ADDR_DATA_BUS_OE_O))
		else $error("Address not driven before strobe falls.");
	a_flush_clears: assert property (@(posedge MCLK_I) disable iff (!RSTN_I)
		(flush_reg && state_reg == ST_IDLE) |=> valid_reg[0] == 8'h00 &&
		valid_reg[1] == 8'h00 && valid_reg[2] == 8'h00 &&
		valid_reg[3] == 8'h00)
		else $error("Flush left a valid flag set.");
	a_done_valid: assert property (@(posedge MCLK_I) disable iff (!RSTN_I)
		(state_reg == ST_DONE && !flush_reg) |=>
		valid_reg[$past(fill_seg_reg)][$past(fill_sub_reg)])
		else $error("Filled subsegment not marked valid.");
	a_partial_keep: assert property (@(posedge MCLK_I) disable iff (!RSTN_I)
		(start_fill && any_match) |=> tag_reg[$past(match_seg)] ==
		$past(pc_tag) && (valid_reg[$past(match_seg)] |
		(8'h01 << $past(pc_sub))) == ($past(valid_reg[match_seg]) |
		(8'h01 << $past(pc_sub))))
		else $error("Partial fill lost the segment tag.");
	a_miss_lru: assert property (@(posedge MCLK_I) disable iff (!RSTN_I)
		(start_fill && !any_match) |=>
		fill_seg_reg == $past(lru_seg))
		else $error("Miss did not replace least recent segment.");
	a_ack_hit: assert property (@(posedge MCLK_I) disable iff (!RSTN_I)
		FETCH_ACK_O |-> $past(hit) && $past(FETCH_REQ_I))
		else $error("Acknowledge without a valid hit.");
	a_narrow_two: assert property (@(posedge MCLK_I) disable iff (!RSTN_I)
		(data_take && !narrow_reg && !fill_half_reg) |=>
		state_reg == ST_ADDR)
		else $error("Narrow bus fill skipped second access.");
	// Each access drives the address, drops the strobe over it, then frees it.
	sequence s_addr_drive;
		LOCAL_ADDR_DATA_BUS_OE_O && ADDRESS_LATCH_STROBE_O;
	endsequence
	sequence s_addr_latch;
		LOCAL_ADDR_DATA_BUS_OE_O && !ADDRESS_LATCH_STROBE_O;
	endsequence
	sequence s_bus_release;
		!LOCAL_ADDR_DATA_BUS_OE_O && ADDRESS_LATCH_STROBE_O && MEM_REQ_O;
	endsequence
	a_access_steps: assert property (@(posedge MCLK_I) disable iff (!RSTN_I)
		$rose(LOCAL_ADDR_DATA_BUS_OE_O) |-> s_addr_drive ##1 s_addr_latch ##1
		s_bus_release)
		else $error("Fill access broke the address and strobe order.");
	a_ack_single: assert property (@(posedge MCLK_I) disable iff (!RSTN_I)
		FETCH_ACK_O |=> !FETCH_ACK_O)
		else $error("Acknowledge held for two cycles.");
	a_req_in_fill: assert property (@(posedge MCLK_I) disable iff (!RSTN_I)
		MEM_REQ_O |-> state_reg != ST_IDLE)
		else $error("Memory request outside a fill.");
	a_wide_half: assert property (@(posedge MCLK_I) disable iff (!RSTN_I)
		(LOCAL_ADDR_DATA_BUS_OE_O && narrow_reg) |->
		!LOCAL_ADDR_DATA_BUS_O[4])
		else $error("Half select set on a 32-bit memory.");
endmodule // slic_cache
`default_nettype wire

// File: rtl/slic_regs.svh
`ifndef SLIC_REGS_SVH
`define SLIC_REGS_SVH
`define SLIC_SEGMENTS      4
`define SLIC_SUBSEGS       8
`define SLIC_WORDS_PER_SUB 4
`define SLIC_TAG_W         22
`define SLIC_WADDR_W       28
`define SLIC_PC_LSB_ZERO   4
`define SLIC_SUB_LSB       7
`define SLIC_WORD_LSB      5
`define SLIC_TAG_LSB       10
`define SLIC_LRU_RESET     8'hE4
`endif

// File: rtl/slic_pkg.sv
package slic_pkg;
	typedef logic [1:0]  slic_seg_t;
	typedef logic [21:0] slic_tag_t;
	typedef logic [2:0]  slic_sub_t;
	typedef logic [1:0]  slic_word_t;
	typedef enum logic [4:0] {
		ST_IDLE  = 5'h01,
		ST_ADDR  = 5'h02,
		ST_LATCH = 5'h04,
		ST_DATA  = 5'h08,
		ST_DONE  = 5'h10
	} slic_state_t;
endpackage

// File: rtl/slic_lru.sv
`timescale 1ns/1ns
`default_nettype none
`include "slic_regs.svh"
module slic_lru (
	input  wire logic                 MCLK_I,
	input  wire logic                 RSTN_I,
	input  wire logic                 touch_i,
	input  wire slic_pkg::slic_seg_t  seg_i,
	output var  slic_pkg::slic_seg_t  lru_o
);
	import slic_pkg::*;
	// Stack entry 0 is most recent, entry 3 least recent.
	logic [7:0] stack_reg;
	logic [7:0] stack_next;
	always_comb begin
		logic hit_seen;
		hit_seen = 1'b0;
		stack_next = stack_reg;
		stack_next[1:0] = seg_i;
		for (int i = 1; i < 4; i++) begin
			if (stack_reg[2*(i-1) +: 2] == seg_i)
				hit_seen = 1'b1;
			if (!hit_seen)
				stack_next[2*i +: 2] = stack_reg[2*(i-1) +: 2];
		end
	end
	always_ff @(posedge MCLK_I or negedge RSTN_I) begin
		if (!RSTN_I)
			stack_reg <= `SLIC_LRU_RESET;
		else if (touch_i)
			stack_reg <= stack_next;
	end
	assign lru_o = stack_reg[7:6];
	a_lru_mru_top: assert property (@(posedge MCLK_I) disable iff (!RSTN_I)
		touch_i |=> stack_reg[1:0] == $past(seg_i))
		else $error("Touched segment not at top of usage stack.");
endmodule // slic_lru
`default_nettype wire

// File: test/slic_mem_model.sv
`timescale 1ns/1ns
`default_nettype none
module slic_mem_model (
	input  wire logic        mclk_i,
	input  wire logic        strobe_i,
	input  wire logic        oe_i,
	input  wire logic        narrow_n_i,
	input  wire logic [3:0]  wait_i,
	input  wire logic [31:0] bus_i,
	output logic             rdy_o,
	output logic [31:0]      data_o,
	output logic [27:0]      addr_o,
	output logic [7:0]       count_o
);
	logic [27:0] a;
	// Ready rises only after the data stands on the bus, and the data turns
	// to its inverse once the cache should already have taken it.
	initial begin
		rdy_o = 1'b0;
		data_o = 32'h0;
		addr_o = 28'h0;
		count_o = 8'h0;
		forever begin
			@(posedge mclk_i);
			if (strobe_i === 1'b0 && oe_i === 1'b1) begin
				a = bus_i[31:4];
				addr_o <= a;
				count_o <= count_o + 8'h1;
				repeat (wait_i) @(posedge mclk_i);
				if (narrow_n_i)
					data_o <= {a[15:0] ^ 16'hA5C2, a[15:0] ^ 16'hA5C3};
				else
					data_o <= {~a[15:0], a[15:0] ^ 16'hA5C3};
				@(posedge mclk_i);
				rdy_o <= 1'b1;
				repeat (4) @(posedge mclk_i);
				rdy_o <= 1'b0;
				repeat (4) @(posedge mclk_i);
				data_o <= ~data_o;
			end
		end
	end
endmodule // slic_mem_model
`default_nettype wire

// File: test/slic_cache_tb.sv
`timescale 1ns/1ns
`default_nettype none
module slic_cache_tb;
	import slic_pkg::*;
	logic        clk, rstn, req, flush, narrow_n;
	logic [31:0] pc;
	logic [3:0]  wt;
	wire         ack, strobe, mem_req, oe, rdy;
	wire  [15:0] instr;
	wire  [31:0] bus_o, mem_data, bus_w;
	wire  [27:0] last_addr;
	wire  [7:0]  cnt;
	int          num_errors, compares;
	assign bus_w = oe ? bus_o : mem_data;
	slic_cache u_slic_cache (.MCLK_I(clk), .RSTN_I(rstn), .FETCH_REQ_I(req),
		.FETCH_PC_I(pc), .FETCH_ACK_O(ack), .FETCH_INSTR_O(instr),
		.FLUSH_REQ_I(flush), .MEM_REQ_O(mem_req), .MEM_RDY_I(rdy),
		.NARROW_BUS_N_I(narrow_n), .ADDRESS_LATCH_STROBE_O(strobe),
		.LOCAL_ADDR_DATA_BUS_I(bus_w), .LOCAL_ADDR_DATA_BUS_O(bus_o),
		.LOCAL_ADDR_DATA_BUS_OE_O(oe));
	slic_mem_model u_slic_mem_model (.mclk_i(clk), .strobe_i(strobe),
		.oe_i(oe), .narrow_n_i(narrow_n), .wait_i(wt), .bus_i(bus_w),
		.rdy_o(rdy), .data_o(mem_data), .addr_o(last_addr), .count_o(cnt));
	initial begin
		clk = 1'b0;
		forever #4 clk = ~clk;
	end
	task automatic wrap_up;
		$display("errors %0d compares %0d", num_errors, compares);
		if (num_errors == 0 && compares > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
		compares++;
		if (got !== exp) begin
			num_errors++;
			$display("CHECK FAILED at %0t: got %h expected %h",
				$time, got, exp);
		end
	endtask
	task automatic do_reset;
		rstn = 1'b0;
		repeat (3) @(negedge clk);
		cmp({28'h0, ack, strobe, mem_req, oe}, 32'h4);
		rstn = 1'b1;
	endtask
	// Fetch one halfword, then check the data and the number of fill accesses.
	task automatic go(input logic [31:0] a, input logic [31:0] n);
		logic [7:0] c0;
		int k;
		c0 = cnt;
		k = 0;
		@(negedge clk);
		pc = a;
		req = 1'b1;
		do begin
			@(posedge clk);
			#1;
			k++;
		end while (ack !== 1'b1 && k < 3000);
		cmp({31'h0, ack}, 32'h1);
		cmp({16'h0, instr}, {16'h0, a[19:4] ^ 16'hA5C3});
		cmp({24'h0, 8'(cnt - c0)}, n);
		cmp({31'h0, mem_req}, 32'h0);
		@(negedge clk);
		req = 1'b0;
	endtask
	task automatic t_basic;
		go(32'h0001_2340, 4);
		cmp({4'h0, last_addr}, 32'h0000_1236);
		go(32'h0001_2340, 0);
		go(32'h0001_236F, 0);
		go(32'h0001_2310, 0);
	endtask
	task automatic t_sub;
		go(32'h0001_23C0, 4);
		go(32'h0001_2350, 0);
	endtask
	task automatic t_flush;
		@(negedge clk);
		flush = 1'b1;
		repeat (6) @(negedge clk);
		flush = 1'b0;
		repeat (4) @(negedge clk);
		go(32'h0001_2340, 4);
		go(32'h0001_23C0, 4);
	endtask
	task automatic t_lru;
		do_reset();
		go(32'h1000_1000, 4);
		go(32'h1000_2000, 4);
		go(32'h1000_3000, 4);
		go(32'h1000_4000, 4);
		go(32'h1000_1000, 0);
		go(32'h1000_5000, 4);
		go(32'h1000_1000, 0);
		go(32'h1000_3000, 0);
		go(32'h1000_4000, 0);
		go(32'h1000_2000, 4);
	endtask
	task automatic t_narrow;
		narrow_n = 1'b0;
		repeat (4) @(negedge clk);
		go(32'h2000_0A80, 8);
		cmp({4'h0, last_addr}, 32'h0200_00AF);
		go(32'h2000_0AF0, 0);
		narrow_n = 1'b1;
		repeat (4) @(negedge clk);
	endtask
	task automatic t_slow;
		wt = 4'hC;
		go(32'h3000_0700, 4);
		go(32'h3000_0760, 0);
		wt = 4'h0;
	endtask
	initial begin
		req = 1'b0;
		flush = 1'b0;
		narrow_n = 1'b1;
		pc = 32'h0;
		wt = 4'h0;
		num_errors = 0;
		compares = 0;
		do_reset();
		t_basic();
		t_sub();
		t_flush();
		t_lru();
		t_narrow();
		t_slow();
		wrap_up();
	end
	initial begin
		#400000;
		num_errors++;
		wrap_up();
	end
endmodule // slic_cache_tb
`default_nettype wire
